// >>> common/radio_packet_handler_pkg.sv
// Behaviour
// - format 0 plus length 0 selects unlimited
// - unlimited sync-off Rx: no filtering/decoding, load rule
// - unlimited: Tx CRC kept, no Rx check/flags
// - Tx adds preamble, sync, CRC, DC-free coding
// - trigger 1: start at first FIFO byte
// - trigger 0: start at threshold plus one
// - condition met earlier: start on entering Tx
// - Rx strips preamble/sync, stores payload only
// - fixed format takes exactly length setting bytes
// - variable: first byte is length, over max discards
// - address byte mismatch stops reception
// - CRC check sets pass flag, output 0 follows available (done in Tx)
// - CRC fail clears FIFO unless purge disabled
// - 16-byte write-only key kept through sleep
// - Tx encrypts message in 16-byte padded blocks first
// - Rx decrypts buffered packet before availability flag
// - CRC checked on ciphertext, pass precedes available
// - cipher time 7.0 us per block
// - encrypted message at most 64, or 48 bytes (Rx caps at 64 in every format)
package radio_packet_handler_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int AES_BLOCK_NS = 7000;
  localparam int AES_MAX_NS = 28000;
  localparam int AES_BLOCK_CYC = (AES_BLOCK_NS * CLK_MHZ) / 1000;
  localparam int AES_MAX_CYC = (AES_MAX_NS * CLK_MHZ) / 1000;

  // ****************************************
  // sizes and constants
  // ****************************************
  localparam int FIFO_DEPTH = 66;
  localparam int AES_BLOCK_BYTES = 16;
  localparam logic [7:0] AES_MAX_MSG = 8'h40;
  localparam logic [7:0] AES_MAX_MSG_VAR_ADDR = 8'h30;
  localparam logic [7:0] PREAMBLE_BYTE = 8'hAA;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [8:0] WHITEN_INIT = 9'h1FF;
  localparam int WHITEN_TAP = 5;
  localparam logic [1:0] DC_NONE = 2'h0;
  localparam logic [1:0] DC_MANCHESTER = 2'h1;
  localparam logic [1:0] DC_WHITEN = 2'h2;

  typedef enum logic [1:0] {
    MODE_SLEEP = 2'h0,
    MODE_STDBY = 2'h1,
    MODE_TX = 2'h2,
    MODE_RX = 2'h3
  } mode_e;

  typedef struct packed {
    logic frame_format_select;
    logic [7:0] length_setting;
    logic transmit_trigger_select;
    logic sync_pattern_enable;
    logic [2:0] sync_size;
    logic [63:0] sync_value;
    logic buffer_load_rule;
    logic checksum_enable;
    logic fail_purge_disable;
    logic addr_filter_enable;
    logic [7:0] station_id;
    logic [6:0] buffer_level_setting;
    logic [15:0] preamble_size;
    logic [1:0] dc_free;
    logic aes_enable;
  } cfg_s;

endpackage

// >>> hdl/radio_packet_handler.sv
`timescale 1ns/1ps
module radio_packet_handler
  import radio_packet_handler_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int BLOCK_CYC = AES_BLOCK_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // mode and configuration
  input wire mode_e mode_i,
  input wire cfg_s cfg_i,
  // cipher key, write only
  input wire logic key_wr_i,
  input wire logic [3:0] key_idx_i,
  input wire logic [7:0] key_byte_i,
  // host byte port
  input wire logic host_wr_i,
  input wire logic [7:0] host_wdata_i,
  input wire logic host_rd_i,
  output logic [7:0] host_rdata_o,
  // modem side
  input wire logic tx_tick_i,
  output logic tx_data_o,
  input wire logic rx_tick_i,
  input wire logic rx_data_i,
  input wire logic sync_detect_i,
  // flags
  output logic buffer_level_flag_o,
  output logic buffer_has_data_flag_o,
  output logic buffer_full_flag_o,
  output logic tx_frame_done_flag_o,
  output logic check_pass_flag_o,
  output logic rx_frame_available_o,
  output logic digital_output_0_o
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_C = (PW + 1)'(DEPTH);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_TX_AES = 4'h1,
    ST_TX_PRE = 4'h2,
    ST_TX_SYNC = 4'h3,
    ST_TX_BODY = 4'h4,
    ST_TX_CRC = 4'h5,
    ST_TX_END = 4'h6,
    ST_RX_HUNT = 4'h7,
    ST_RX_BODY = 4'h8,
    ST_RX_CRC = 4'h9,
    ST_RX_AES = 4'hA,
    ST_RX_DONE = 4'hB
  } fsm_e;

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [15:0][7:0] key;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] pkt_base;
    logic [PW:0] cnt;
    logic [7:0] rdata;
    fsm_e st;
    logic [15:0] pre_left;
    logic [7:0] idx;
    logic [7:0] plen;
    logic [7:0] shreg;
    logic [2:0] bitn;
    logic have;
    logic chip;
    logic coded;
    logic raw0;
    logic [15:0] crc;
    logic [15:0] crc_rx;
    logic [8:0] lfsr;
    logic txbit;
    logic done;
    logic crc_ok;
    logic avail;
    logic digital_output_0;
    logic lvl;
    logic nemp;
    logic full;
    logic [7:0] aes_i;
    logic [7:0] aes_n;
    logic [7:0] aes_av;
    logic [11:0] aes_t;
  } state_s;

  state_s q;
  state_s d;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [PW-1:0] fpos(input logic [PW-1:0] base, input logic [7:0] off);
    logic [8:0] s;
    s = 9'(base) + 9'(off);
    if (s >= 9'(DEPTH)) begin
      s = s - 9'(DEPTH);
    end
    return s[PW-1:0];
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ b[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  function automatic logic [8:0] lfsr_step(input logic [8:0] l);
    return {l[0] ^ l[WHITEN_TAP], l[8:1]};
  endfunction

  // ****************************************
  // next state
  // ****************************************
  logic unlimited;
  logic filt_ok;
  logic [7:0] hdr;
  logic [7:0] msg;
  logic [7:0] blocks;
  logic push;
  logic pop_e;
  logic pop_h;
  logic [7:0] pdat;
  logic purge;
  logic rbit;
  logic rbyte;
  logic [7:0] rb;
  logic body_end;
  logic start_ok;
  logic [7:0] nb;
  logic cbit;

  always_comb begin
    d = q;
    push = 1'b0;
    pop_e = 1'b0;
    pop_h = 1'b0;
    pdat = 8'h00;
    purge = 1'b0;
    rbit = 1'b0;
    rbyte = 1'b0;
    rb = 8'h00;
    body_end = 1'b0;
    nb = 8'h00;
    cbit = 1'b0;
    unlimited = !cfg_i.frame_format_select && cfg_i.length_setting == 8'h00;
    filt_ok = !(unlimited && !cfg_i.sync_pattern_enable);
    hdr = {7'h00, cfg_i.frame_format_select} + {7'h00, cfg_i.addr_filter_enable};
    msg = 8'(q.cnt) - hdr;
    if (cfg_i.frame_format_select && cfg_i.addr_filter_enable && msg > AES_MAX_MSG_VAR_ADDR) begin
      msg = AES_MAX_MSG_VAR_ADDR;
    end else if (msg > AES_MAX_MSG) begin
      msg = AES_MAX_MSG;
    end
    blocks = (msg + 8'(AES_BLOCK_BYTES - 1)) >> 4;
    // trigger 0 counts threshold plus one; reached or passed both start
    start_ok = cfg_i.transmit_trigger_select ? (q.cnt != '0)
             : (q.cnt >= (PW + 1)'(cfg_i.buffer_level_setting) + 1'b1);

    if (key_wr_i) begin
      d.key[key_idx_i] = key_byte_i;
    end

    // host port; engine owns the read side during Tx
    if (host_rd_i && q.cnt != '0 && mode_i != MODE_TX) begin
      d.rdata = q.mem[q.rd_ptr];
      pop_h = 1'b1;
    end
    if (host_wr_i && q.cnt != DEPTH_C && mode_i != MODE_RX && q.st != ST_TX_AES) begin
      push = 1'b1;
      pdat = host_wdata_i;
    end

    // tx serializer, manchester sends b then ~b per bit
    if (tx_tick_i && q.have) begin
      cbit = q.shreg[7] ^ (q.coded && cfg_i.dc_free == DC_WHITEN && q.lfsr[0]);
      if (q.coded && cfg_i.dc_free == DC_MANCHESTER) begin
        d.txbit = q.chip ? !cbit : cbit;
        d.chip = !q.chip;
      end else begin
        d.txbit = cbit;
      end
      if (!q.coded || cfg_i.dc_free != DC_MANCHESTER || q.chip) begin
        if (q.coded && cfg_i.dc_free == DC_WHITEN) begin
          d.lfsr = lfsr_step(q.lfsr);
        end
        d.shreg = {q.shreg[6:0], 1'b0};
        d.bitn = q.bitn + 3'h1;
        if (q.bitn == 3'h7) begin
          d.have = 1'b0;
        end
      end
    end

    // rx deserializer, manchester keeps the first chip of each pair
    if (rx_tick_i && (q.st == ST_RX_BODY || q.st == ST_RX_CRC)) begin
      if (filt_ok && cfg_i.dc_free == DC_MANCHESTER && !q.chip) begin
        d.chip = 1'b1;
        d.raw0 = rx_data_i;
      end else begin
        d.chip = 1'b0;
        rbit = (filt_ok && cfg_i.dc_free == DC_MANCHESTER) ? q.raw0 : rx_data_i;
        if (filt_ok && cfg_i.dc_free == DC_WHITEN) begin
          rbit = rbit ^ q.lfsr[0];
          d.lfsr = lfsr_step(q.lfsr);
        end
        d.shreg = {q.shreg[6:0], rbit};
        d.bitn = q.bitn + 3'h1;
        rbyte = q.bitn == 3'h7;
        rb = {q.shreg[6:0], rbit};
      end
    end

    unique case (q.st)
      ST_IDLE: begin
        d.chip = 1'b0;
        d.have = 1'b0;
        d.txbit = 1'b0;
        if (mode_i == MODE_TX && start_ok) begin
          d.pre_left = cfg_i.preamble_size;
          if (cfg_i.aes_enable) begin
            d.st = ST_TX_AES;
            d.pkt_base = fpos(q.rd_ptr, hdr);
            d.aes_i = 8'h00;
            d.aes_av = msg;
            d.aes_n = blocks << 4;
            d.aes_t = 12'(blocks) * 12'(BLOCK_CYC);
          end else begin
            d.st = ST_TX_PRE;
          end
        end else if (mode_i == MODE_RX) begin
          d.st = ST_RX_HUNT;
        end
      end
      ST_TX_AES, ST_RX_AES: begin
        if (q.aes_t != 12'h000) begin
          d.aes_t = q.aes_t - 12'h001;
        end
        if (q.aes_i != q.aes_n) begin
          if (q.aes_i < q.aes_av) begin
            d.mem[fpos(q.pkt_base, q.aes_i)] = q.mem[fpos(q.pkt_base, q.aes_i)] ^ q.key[q.aes_i[3:0]];
          end else begin
            push = 1'b1;
            pdat = q.key[q.aes_i[3:0]];
          end
          d.aes_i = q.aes_i + 8'h01;
        end else if (q.aes_t == 12'h000) begin
          if (q.st == ST_TX_AES) begin
            d.st = ST_TX_PRE;
          end else begin
            d.st = ST_RX_DONE;
            d.avail = 1'b1;
          end
        end
      end
      ST_TX_PRE: begin
        if (!q.have) begin
          if (q.pre_left == 16'h0000) begin
            d.st = ST_TX_SYNC;
            d.idx = 8'h00;
          end else begin
            d.pre_left = q.pre_left - 16'h0001;
            d.shreg = PREAMBLE_BYTE;
            d.have = 1'b1;
            d.coded = 1'b0;
          end
        end
      end
      ST_TX_SYNC: begin
        if (!q.have) begin
          if (!cfg_i.sync_pattern_enable || q.idx > 8'(cfg_i.sync_size)) begin
            d.st = ST_TX_BODY;
            d.idx = 8'h00;
            d.crc = CRC_INIT;
            d.lfsr = WHITEN_INIT;
          end else begin
            d.shreg = cfg_i.sync_value[8'd63 - {q.idx[2:0], 3'b000} -: 8];
            d.have = 1'b1;
            d.coded = 1'b0;
            d.idx = q.idx + 8'h01;
          end
        end
      end
      ST_TX_BODY: begin
        if (cfg_i.aes_enable || unlimited) begin
          body_end = q.cnt == '0;
        end else if (cfg_i.frame_format_select) begin
          body_end = q.idx != 8'h00 && q.idx == q.plen + 8'h01;
        end else begin
          body_end = q.idx == cfg_i.length_setting;
        end
        if (!q.have) begin
          if (body_end) begin
            d.st = cfg_i.checksum_enable ? ST_TX_CRC : ST_TX_END;
            d.idx = 8'h00;
          end else if (q.cnt != '0) begin
            pop_e = 1'b1;
            nb = q.mem[q.rd_ptr];
            d.shreg = nb;
            d.have = 1'b1;
            d.coded = 1'b1;
            d.crc = crc_byte(q.crc, nb);
            d.idx = q.idx + 8'h01;
            if (q.idx == 8'h00) begin
              d.plen = nb;
            end
          end
        end
      end
      ST_TX_CRC: begin
        if (!q.have) begin
          d.shreg = (q.idx == 8'h00) ? q.crc[15:8] : q.crc[7:0];
          d.have = 1'b1;
          d.coded = 1'b1;
          d.idx = q.idx + 8'h01;
          if (q.idx == 8'h01) begin
            d.st = ST_TX_END;
          end
        end
      end
      ST_TX_END: begin
        if (!q.have) begin
          d.done = 1'b1;
        end
      end
      // a fresh sync word restarts after a finished frame
      ST_RX_HUNT, ST_RX_DONE: begin
        if (sync_detect_i || (!cfg_i.sync_pattern_enable && unlimited && cfg_i.buffer_load_rule)) begin
          d.st = ST_RX_BODY;
          d.idx = 8'h00;
          d.bitn = 3'h0;
          d.chip = 1'b0;
          d.crc = CRC_INIT;
          d.lfsr = WHITEN_INIT;
          d.crc_ok = 1'b0;
          d.avail = 1'b0;
          d.pkt_base = q.wr_ptr;
        end
      end
      ST_RX_BODY: begin
        if (rbyte) begin
          d.crc = crc_byte(q.crc, rb);
          d.idx = q.idx + 8'h01;
          if (q.cnt != DEPTH_C) begin
            push = 1'b1;
            pdat = rb;
          end
          if (cfg_i.frame_format_select && q.idx == 8'h00) begin
            d.plen = rb;
          end
          if (cfg_i.frame_format_select && q.idx == 8'h00 && rb > cfg_i.length_setting) begin
            purge = 1'b1;
          end else if (filt_ok && cfg_i.addr_filter_enable && q.idx == {7'h00, cfg_i.frame_format_select}
                       && rb != cfg_i.station_id) begin
            purge = 1'b1;
          end else if (!unlimited && ((cfg_i.frame_format_select && q.idx != 8'h00 && q.idx == q.plen)
                       || (!cfg_i.frame_format_select && q.idx + 8'h01 == cfg_i.length_setting))) begin
            if (cfg_i.checksum_enable) begin
              d.st = ST_RX_CRC;
              d.idx = 8'h00;
            end else if (cfg_i.aes_enable) begin
              d.st = ST_RX_AES;
            end else begin
              d.st = ST_RX_DONE;
              d.avail = 1'b1;
            end
          end
          if (purge) begin
            d.st = ST_RX_HUNT;
          end
        end
      end
      ST_RX_CRC: begin
        if (rbyte) begin
          d.crc_rx = {q.crc_rx[7:0], rb};
          d.idx = q.idx + 8'h01;
          if (q.idx == 8'h01) begin
            d.crc_ok = {q.crc_rx[7:0], rb} == q.crc;
            if ({q.crc_rx[7:0], rb} != q.crc && !cfg_i.fail_purge_disable) begin
              purge = 1'b1;
              d.st = ST_RX_HUNT;
            end else if (cfg_i.aes_enable) begin
              d.st = ST_RX_AES;
            end else begin
              d.st = ST_RX_DONE;
              d.avail = 1'b1;
            end
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    // rx aes setup on the buffered message
    if (q.st != ST_RX_AES && d.st == ST_RX_AES) begin
      d.aes_i = 8'h00;
      d.aes_av = ((8'(q.cnt) + 8'(push) - hdr) > AES_MAX_MSG) ? AES_MAX_MSG : 8'(q.cnt) + 8'(push) - hdr;
      d.aes_n = d.aes_av;
      d.aes_t = 12'((d.aes_av + 8'(AES_BLOCK_BYTES - 1)) >> 4) * 12'(BLOCK_CYC);
      d.pkt_base = fpos(q.pkt_base, hdr);
    end

    // leaving the active mode ends the frame
    if ((mode_i != MODE_TX && q.st >= ST_TX_AES && q.st <= ST_TX_END)
        || (mode_i != MODE_RX && q.st >= ST_RX_HUNT && q.st != ST_RX_DONE)
        || (q.st == ST_RX_DONE && mode_i != MODE_RX)) begin
      d.st = ST_IDLE;
      d.done = 1'b0;
    end

    // fifo pointer update
    if (push) begin
      d.mem[q.wr_ptr] = pdat;
      d.wr_ptr = fpos(q.wr_ptr, 8'h01);
    end
    if (pop_e || pop_h) begin
      d.rd_ptr = fpos(q.rd_ptr, 8'h01);
    end
    d.cnt = q.cnt + (PW + 1)'(push) - (PW + 1)'(pop_e || pop_h);
    if (purge) begin
      d.wr_ptr = '0;
      d.rd_ptr = '0;
      d.cnt = '0;
    end
    // availability drops once the host has drained the buffer
    if (q.avail && d.cnt == '0 && pop_h) begin
      d.avail = 1'b0;
    end
    if (unlimited) begin
      d.crc_ok = 1'b0;
      d.avail = 1'b0;
    end

    d.lvl = d.cnt > (PW + 1)'(cfg_i.buffer_level_setting);
    d.nemp = d.cnt != '0;
    d.full = d.cnt == DEPTH_C;
    d.digital_output_0 = (mode_i == MODE_TX) ? d.done : d.avail;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.crc <= CRC_INIT;
      q.lfsr <= WHITEN_INIT;
    end else begin
      q <= d;
    end
  end

  assign host_rdata_o = q.rdata;
  assign tx_data_o = q.txbit;
  assign buffer_level_flag_o = q.lvl;
  assign buffer_has_data_flag_o = q.nemp;
  assign buffer_full_flag_o = q.full;
  assign tx_frame_done_flag_o = q.done;
  assign check_pass_flag_o = q.crc_ok;
  assign rx_frame_available_o = q.avail;
  assign digital_output_0_o = q.digital_output_0;

endmodule

// >>> tb/radio_packet_handler_props.sv
`timescale 1ns/1ps
module radio_packet_handler_props
  import radio_packet_handler_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int BLOCK_CYC = AES_BLOCK_CYC
) (
  // clock, reset and settings
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire mode_e mode_i,
  input wire cfg_s cfg_i,
  // host and modem side
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [7:0] host_rdata_o,
  input wire logic tx_tick_i,
  input wire logic tx_data_o,
  // flags
  input wire logic buffer_has_data_flag_o,
  input wire logic buffer_full_flag_o,
  input wire logic tx_frame_done_flag_o,
  input wire logic check_pass_flag_o,
  input wire logic rx_frame_available_o,
  input wire logic digital_output_0_o
);
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic unlim;
  assign unlim = !cfg_i.frame_format_select && cfg_i.length_setting == 8'h00;

  a_write_sets_data: assert property ((host_wr_i && mode_i == MODE_STDBY && !buffer_full_flag_o) |=>
    buffer_has_data_flag_o) else $error("accepted write left buffer empty");
  a_read_refused: assert property ((host_rd_i && (!buffer_has_data_flag_o || mode_i == MODE_TX)) |=>
    $stable(host_rdata_o)) else $error("refused read changed read data");
  a_pass_needs_crc: assert property ($rose(check_pass_flag_o) |-> cfg_i.checksum_enable && !unlim)
    else $error("pass flag without checking");
  a_unlim_no_flags: assert property ((mode_i == MODE_RX && unlim) |=> !$rose(rx_frame_available_o))
    else $error("available flag in unlimited format");
  a_avail_after_pass: assert property (($rose(rx_frame_available_o) && cfg_i.checksum_enable
    && !cfg_i.fail_purge_disable && !unlim) |-> check_pass_flag_o) else $error("frame offered after bad check");
  a_done_in_tx: assert property ($rose(tx_frame_done_flag_o) |-> $past(mode_i) == MODE_TX)
    else $error("done flag outside transmit");
  a_digital_output_0_done: assert property (($rose(tx_frame_done_flag_o) && mode_i == MODE_TX) |-> ##[0:1]
    digital_output_0_o) else $error("output 0 missed done flag");
  a_chip_hold: assert property ((mode_i == MODE_TX && !tx_tick_i) ##1 (mode_i == MODE_TX) |->
    $stable(tx_data_o)) else $error("chip changed without tick");

  c_done: cover property ($rose(tx_frame_done_flag_o));
  c_pass: cover property ($rose(check_pass_flag_o));
  c_full: cover property ($rose(buffer_full_flag_o));
endmodule

bind radio_packet_handler radio_packet_handler_props #(.DEPTH(DEPTH), .BLOCK_CYC(BLOCK_CYC)) u_props (
  .sys_clk_i(sys_clk_i),
  .arst_n_i(arst_n_i),
  .mode_i(mode_i),
  .cfg_i(cfg_i),
  .host_wr_i(host_wr_i),
  .host_rd_i(host_rd_i),
  .host_rdata_o(host_rdata_o),
  .tx_tick_i(tx_tick_i),
  .tx_data_o(tx_data_o),
  .buffer_has_data_flag_o(buffer_has_data_flag_o),
  .buffer_full_flag_o(buffer_full_flag_o),
  .tx_frame_done_flag_o(tx_frame_done_flag_o),
  .check_pass_flag_o(check_pass_flag_o),
  .rx_frame_available_o(rx_frame_available_o),
  .digital_output_0_o(digital_output_0_o)
);

// >>> tb/host_model.sv
`timescale 1ns/1ps
module host_model (
  // clock, flags and read data
  input wire logic sys_clk_i,
  input wire logic buffer_has_data_flag_i,
  input wire logic buffer_full_flag_i,
  input wire logic [7:0] host_rdata_i,
  // byte port
  output logic host_wr_o,
  output logic [7:0] host_wdata_o,
  output logic host_rd_o
);
  // ****************************************
  // byte transfers, one cycle each
  // ****************************************
  initial begin
    host_wr_o = 1'b0;
    host_wdata_o = 8'h00;
    host_rd_o = 1'b0;
  end
  task automatic put(input logic [7:0] b);
    @(negedge sys_clk_i);
    host_wr_o = 1'b1;
    host_wdata_o = b;
    @(negedge sys_clk_i);
    host_wr_o = 1'b0;
    host_wdata_o = ~b;  // released data must not look valid
  endtask
  task automatic get(output logic [7:0] b);
    @(negedge sys_clk_i);
    host_rd_o = 1'b1;
    @(negedge sys_clk_i);
    host_rd_o = 1'b0;
    b = host_rdata_i;
  endtask
  // bounded so a full flag that never rises cannot hang the host
  task automatic refill(input logic [7:0] first, output int n);
    n = 0;
    while (!buffer_full_flag_i && n < 100) begin
      put(first + n[7:0]);
      n++;
    end
  endtask
  task automatic drain(output logic [7:0] q[$]);
    logic [7:0] b;
    q = {};
    while (buffer_has_data_flag_i && q.size() < 100) begin
      get(b);
      q.push_back(b);
    end
  endtask
endmodule

// >>> tb/radio_packet_handler_tb_top.sv
`timescale 1ns/1ps
module radio_packet_handler_tb_top import radio_packet_handler_pkg::*;;
  logic sys_clk, arst_n, key_wr, host_wr, host_rd, tx_tick, tx_data, rx_tick, rx_data, sync_det;
  logic [3:0] key_idx;
  logic [7:0] key_byte, host_wdata, host_rdata;
  logic lvl, has_data, full, done, pass, avail, digital_output_0;
  mode_e mode;
  cfg_s cfg;
  int fails, checked;

  radio_packet_handler #(.DEPTH(FIFO_DEPTH), .BLOCK_CYC(20)) dut (.sys_clk_i(sys_clk), .arst_n_i(arst_n),
    .mode_i(mode), .cfg_i(cfg), .key_wr_i(key_wr), .key_idx_i(key_idx), .key_byte_i(key_byte),
    .host_wr_i(host_wr), .host_wdata_i(host_wdata), .host_rd_i(host_rd), .host_rdata_o(host_rdata),
    .tx_tick_i(tx_tick), .tx_data_o(tx_data), .rx_tick_i(rx_tick), .rx_data_i(rx_data),
    .sync_detect_i(sync_det), .buffer_level_flag_o(lvl), .buffer_has_data_flag_o(has_data),
    .buffer_full_flag_o(full), .tx_frame_done_flag_o(done), .check_pass_flag_o(pass),
    .rx_frame_available_o(avail), .digital_output_0_o(digital_output_0));
  host_model hst (.sys_clk_i(sys_clk), .buffer_has_data_flag_i(has_data), .buffer_full_flag_i(full),
    .host_rdata_i(host_rdata), .host_wr_o(host_wr), .host_wdata_o(host_wdata), .host_rd_o(host_rd));

  // ****************************************
  // helpers
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = (c[15] ^ b[i]) ? {c[14:0], 1'b0} ^ CRC_POLY : {c[14:0], 1'b0};
    return c;
  endfunction
  task automatic chips(input int n, output logic [47:0] v);
    v = '0;
    repeat (n) begin
      @(negedge sys_clk);
      tx_tick = 1'b1;
      @(negedge sys_clk);
      tx_tick = 1'b0;
      @(negedge sys_clk);
      v = {v[46:0], tx_data};
    end
  endtask
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(negedge sys_clk);
      rx_data = b[i];
      rx_tick = 1'b1;
      @(negedge sys_clk);
      rx_tick = 1'b0;
      rx_data = ~b[i];  // line keeps no stale bit between ticks
      @(negedge sys_clk);
    end
  endtask
  task automatic rx_frame(input logic [7:0] f[$], input logic bad);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (f[i]) c = crc16(c, f[i]);
    c = c ^ {15'h0, bad};
    mode = MODE_RX;
    @(negedge sys_clk);
    sync_det = 1'b1;
    @(negedge sys_clk);
    sync_det = 1'b0;
    foreach (f[i]) send_byte(f[i]);
    send_byte(c[15:8]);
    send_byte(c[7:0]);
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic rx_check(input logic [7:0] f[$], input logic ok, input logic pass_exp);
    logic [7:0] q[$];
    cmp(48'({pass, avail, digital_output_0}), 48'({pass_exp, ok, ok}));
    hst.drain(q);
    cmp(48'(q.size()), ok ? 48'(f.size()) : 48'h0);
    foreach (q[i]) cmp(48'(q[i]), 48'(f[i]));
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_fifo;
    int n;
    logic [7:0] q[$];
    hst.refill(8'h10, n);
    cmp(48'(n), 48'(FIFO_DEPTH));
    cmp(48'({lvl, has_data, full}), 48'h7);
    hst.put(8'hEE);  // refused, buffer is full
    hst.drain(q);
    cmp(48'(q.size()), 48'(FIFO_DEPTH));
    foreach (q[i]) cmp(48'(q[i]), 48'(8'h10 + i[7:0]));
    cmp(48'({lvl, has_data, full}), 48'h0);
  endtask
  task automatic t_tx(input logic trig, input logic pre);
    logic [47:0] v;
    logic [15:0] tc;
    logic part;
    int k;
    part = trig && !pre;
    tc = crc16(crc16(CRC_INIT, 8'h81), 8'h7E);
    cfg.transmit_trigger_select = trig;
    if (pre) hst.put(8'h81);
    if (pre) hst.put(8'h7E);
    @(negedge sys_clk);
    mode = MODE_TX;
    repeat (4) @(negedge sys_clk);
    if (!pre) begin
      hst.put(8'h81);
      repeat (3) @(negedge sys_clk);
      chips(8, v);
      cmp(v, trig ? 48'hAA : 48'h0);
      hst.put(8'h7E);
    end
    repeat (3) @(negedge sys_clk);
    chips(part ? 40 : 48, v);
    cmp(v, {part ? 8'h00 : 8'hAA, 8'h5A, 8'h81, 8'h7E, tc});
    k = 0;
    while (done !== 1'b1 && k < 4) begin
      chips(1, v);
      k++;
    end
    cmp(48'({done, digital_output_0}), 48'h3);
    mode = MODE_STDBY;
    repeat (3) @(negedge sys_clk);
    cmp(48'(done), 48'h0);
  endtask
  task automatic t_crc;
    for (int i = 0; i < 3; i++) begin
      cfg.fail_purge_disable = (i == 2);
      rx_frame({8'h3C, 8'h96}, i != 0);
      rx_check({8'h3C, 8'h96}, i != 1, i == 0);
    end
    cfg.fail_purge_disable = 1'b0;
  endtask
  task automatic t_aes;
    for (int i = 0; i < 2; i++) begin
      @(negedge sys_clk);
      {key_wr, key_idx, key_byte} = {1'b1, 4'(i), 8'(8'h11 * (i + 1))};
    end
    @(negedge sys_clk);
    key_wr = 1'b0;
    cfg.length_setting = 8'h03;
    cfg.addr_filter_enable = 1'b1;
    cfg.station_id = 8'h42;
    cfg.aes_enable = 1'b1;
    rx_frame({8'h42, 8'h3C, 8'h96}, 1'b0);
    cmp(48'({pass, avail}), 48'h2);
    repeat (24) @(negedge sys_clk);
    rx_check({8'h42, 8'h2D, 8'hB4}, 1'b1, 1'b1);
    cfg.aes_enable = 1'b0;
  endtask
  task automatic t_var;
    cfg.frame_format_select = 1'b1;
    cfg.length_setting = 8'h03;
    cfg.addr_filter_enable = 1'b1;
    cfg.station_id = 8'h42;
    rx_frame({8'h03, 8'h42, 8'h55, 8'h66}, 1'b0);
    rx_check({8'h03, 8'h42, 8'h55, 8'h66}, 1'b1, 1'b1);
    rx_frame({8'h04, 8'h42, 8'h55, 8'h66}, 1'b0);
    rx_check({8'h04}, 1'b0, 1'b0);
    rx_frame({8'h03, 8'h43, 8'h55, 8'h66}, 1'b0);
    rx_check({8'h03}, 1'b0, 1'b0);
    cfg.frame_format_select = 1'b0;
    cfg.addr_filter_enable = 1'b0;
  endtask
  task automatic t_unlim;
    logic [7:0] q[$];
    cfg.length_setting = 8'h00;
    rx_frame({8'hA5, 8'h0F}, 1'b0);
    cmp(48'({pass, avail}), 48'h0);
    hst.drain(q);
    cmp(48'(q.size()), 48'h4);
    mode = MODE_STDBY;
  endtask

  initial begin
    {arst_n, key_wr, tx_tick, rx_tick, rx_data, sync_det} = '0;
    key_idx = 4'h0;
    key_byte = 8'h00;
    fails = 0;
    checked = 0;
    cfg = '0;
    cfg.sync_pattern_enable = 1'b1;
    cfg.sync_value = {8'h5A, 56'h0};
    cfg.preamble_size = 16'h0001;
    cfg.buffer_level_setting = 7'h01;
    cfg.length_setting = 8'h02;
    cfg.checksum_enable = 1'b1;
    mode = MODE_STDBY;
    repeat (8) @(negedge sys_clk);
    arst_n = 1'b1;
    @(negedge sys_clk);
    cmp(48'({lvl, has_data, full, done, pass, avail, digital_output_0}), 48'h0);
    t_fifo;
    t_tx(1'b1, 1'b0);
    t_tx(1'b0, 1'b0);
    t_tx(1'b0, 1'b1);
    t_crc;
    t_aes;
    t_var;
    t_unlim;
    give_verdict;
  end
  // whole run needs under two thousand cycles
  initial begin
    repeat (30000) @(posedge sys_clk);
    fails++;
    give_verdict;
  end
endmodule
